// file: core/mfsl_pkg.sv
// Shared constants and carrier types of the motor frequent start limiter
package mfsl_pkg;
  // Clock and minute time base
  localparam int     CLK_PERIOD_NS     = 8;
  localparam longint MINUTE_NS         = 64'd60_000_000_000;
  localparam longint MINUTE_CYCLES     = MINUTE_NS / CLK_PERIOD_NS;
  localparam int     HOUR_MIN          = 60;
  localparam int     FORCE_TIMEOUT_MIN = 5;
  // Stopped level is a tenth of nominal
  localparam int     NOMINAL_DIV       = 10;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_NOMINAL  = 8'h04;
  localparam logic [7:0] OFS_START_TH = 8'h08;
  localparam logic [7:0] OFS_MAXSTART = 8'h0c;
  localparam logic [7:0] OFS_INTERVAL = 8'h10;
  localparam logic [7:0] OFS_STATUS   = 8'h14;
  localparam logic [7:0] OFS_COUNTER  = 8'h18;
  localparam logic [7:0] OFS_SINCE    = 8'h1c;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h20;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h24;
  localparam logic [7:0] OFS_MATRIX   = 8'h28;
  localparam logic [7:0] OFS_FORCEVAL = 8'h2c;
  localparam logic [7:0] OFS_REC_STMP = 8'h30;
  localparam logic [7:0] OFS_REC_INFO = 8'h34;
  localparam logic [7:0] OFS_REC_TOT  = 8'h38;
  // CTRL fields
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_FORCE_BIT  = 1;
  // Reset values
  localparam logic [15:0] NOMINAL_RST  = 16'h0100;
  localparam logic [15:0] START_TH_RST = 16'h0200;
  localparam logic [7:0]  MAXSTART_RST = 8'h03;
  localparam logic [7:0]  INTERVAL_RST = 8'h14;
  // Event bit positions in IRQ status and mask
  localparam int EV_ALARM_ON  = 0;
  localparam int EV_ALARM_OFF = 1;
  localparam int EV_INHIBIT   = 2;
  localparam int EV_PERMIT    = 3;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;
  // Fault type codes of a trip record
  localparam logic [1:0] FT_INTERVAL = 2'h1;
  localparam logic [1:0] FT_HOURLY   = 2'h2;
  // One trip record
  typedef struct packed {
    logic [31:0] stamp_min;  // Uptime minute of the trip
    logic [7:0]  starts_hr;  // Starts in the last hour
    logic [15:0] since_min;  // Minutes since last start
    logic [31:0] total;      // Total motor starts
    logic [1:0]  ftype;      // Fault type
  } mfsl_trip_t;
endpackage : mfsl_pkg

// file: core/mfsl_minute_tick.sv
// Minute time base prescaler
`timescale 1ns/10ps
`default_nettype none
module mfsl_minute_tick
  import mfsl_pkg::*;
#(
  parameter longint TICK_CYCLES = MINUTE_CYCLES
) (
  input  wire logic clk_in,
  input  wire logic reset_n_in,
  output logic      tick_out
);
  // State: cycle counter and tick pulse
  typedef struct packed {
    logic [39:0] cnt;
    logic        tick;
  } mfsl_tick_st_t;

  mfsl_tick_st_t r;       // Registered state
  mfsl_tick_st_t next_r;  // Next state

  // Count cycles, pulse once per minute
  always_comb
  begin
    next_r      = r;
    next_r.tick = 1'b0;
    if (r.cnt >= 40'(TICK_CYCLES - 1))
    begin
      next_r.cnt  = '0;
      next_r.tick = 1'b1;
    end
    else
      next_r.cnt = r.cnt + 40'd1;
  end

  // Register the state
  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
      r <= '0;
    else
      r <= next_r;
  end

  assign tick_out = r.tick;
endmodule : mfsl_minute_tick
`default_nettype wire

// file: core/mfsl_hour_window.sv
// Rolling one-hour window of start counts in minute buckets
`timescale 1ns/10ps
`default_nettype none
module mfsl_hour_window
  import mfsl_pkg::*;
#(
  parameter int DEPTH = HOUR_MIN,
  parameter int W     = 8
) (
  input  wire logic         clk_in,
  input  wire logic         reset_n_in,
  input  wire logic         tick_in,
  input  wire logic         start_in,
  output logic [W-1:0]      count_out
);
  // State: buckets, write slot and running sum
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] bkt;
    logic [7:0]              idx;
    logic [W-1:0]            sum;
  } mfsl_win_st_t;

  mfsl_win_st_t r;       // Registered state
  mfsl_win_st_t next_r;  // Next state

  // Minute tick retires the oldest bucket before the new start lands
  always_comb
  begin
    next_r = r;
    if (tick_in)
    begin
      next_r.idx = (r.idx == 8'(DEPTH - 1)) ? 8'h00 : r.idx + 8'h01;
      next_r.sum = next_r.sum - r.bkt[next_r.idx];
      next_r.bkt[next_r.idx] = '0;
    end
    if (start_in)
    begin
      next_r.bkt[next_r.idx] = next_r.bkt[next_r.idx] + W'(1);
      next_r.sum = next_r.sum + W'(1);
    end
  end

  // Register the state
  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
      r <= '0;
    else
      r <= next_r;
  end

  assign count_out = r.sum;
endmodule : mfsl_hour_window
`default_nettype wire

// file: core/mfsl_top.sv
// Motor frequent start limiter with AXI4-Lite registers
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module mfsl_top
  import mfsl_pkg::*;
#(
  parameter int     NCONT       = 4,              // Output contacts
  parameter longint TICK_CYCLES = MINUTE_CYCLES   // Cycles per minute
) (
  input  wire logic             CLK_SYS_IN,
  input  wire logic             RESET_N_IN,
  input  wire logic [15:0]      CURRENT_IN,        // Motor current magnitude
  input  wire logic             PANEL_BUTTON_IN,   // Front panel press, one cycle
  input  wire logic [7:0]       S_AXI_AWADDR_IN,
  input  wire logic             S_AXI_AWVALID_IN,
  output logic                  S_AXI_AWREADY_OUT,
  input  wire logic [31:0]      S_AXI_WDATA_IN,
  input  wire logic [3:0]       S_AXI_WSTRB_IN,
  input  wire logic             S_AXI_WVALID_IN,
  output logic                  S_AXI_WREADY_OUT,
  output logic [1:0]            S_AXI_BRESP_OUT,
  output logic                  S_AXI_BVALID_OUT,
  input  wire logic             S_AXI_BREADY_IN,
  input  wire logic [7:0]       S_AXI_ARADDR_IN,
  input  wire logic             S_AXI_ARVALID_IN,
  output logic                  S_AXI_ARREADY_OUT,
  output logic [31:0]           S_AXI_RDATA_OUT,
  output logic [1:0]            S_AXI_RRESP_OUT,
  output logic                  S_AXI_RVALID_OUT,
  input  wire logic             S_AXI_RREADY_IN,
  output logic                  ALARM_OUT,         // Stage alarm
  output logic                  INHIBIT_OUT,       // Motor start inhibit
  output logic [NCONT-1:0]      CONTACT_OUT,       // Matrix-driven contacts
  output logic                  IRQ_OUT            // Level interrupt
);
  // Whole block state
  typedef struct packed {
    logic              enable;      // Stage enabled
    logic              force_on;    // Test forcing flag
    logic [2:0]        force_left;  // Minutes until force clears
    logic [1:0]        force_val;   // Forced alarm, inhibit
    logic [15:0]       nominal;     // Motor nominal current
    logic [15:0]       start_th;    // stall_stage_start_threshold
    logic [7:0]        max_starts;  // Max starts per hour
    logic [7:0]        interval;    // Min minutes between starts
    logic              armed;       // Seen below tenth nominal
    logic              running;     // Motor considered running
    logic              any_start;   // At least one start seen
    logic [15:0]       since_min;   // time_since_last_start
    logic [31:0]       counter;     // stage_start_counter
    logic [31:0]       uptime_min;  // Minute stamp base
    logic [7:0]        ivl_left;    // Interval inhibit minutes left
    logic [6:0]        hour_left;   // Hourly inhibit minutes left
    logic [6:0]        alarm_left;  // Alarm minutes left
    logic              alarm;       // Stage alarm
    logic              inhibit;     // Stage inhibit
    logic [3:0]        irq_stat;    // Sticky events
    logic [3:0]        irq_mask;    // Event enables
    logic [2*NCONT-1:0] matrix;     // Per contact: inhibit, alarm
    logic [NCONT-1:0]  contact;     // Contact outputs
    mfsl_trip_t        trip_record; // Last trip
    logic              bvalid;      // Write response pending
    logic [1:0]        bresp;       // Write response code
    logic              rvalid;      // Read data pending
    logic [1:0]        rresp;       // Read response code
    logic [31:0]       rdata;       // Read data
  } mfsl_state_t;

  mfsl_state_t r;       // Registered state
  mfsl_state_t next_r;  // Next state

  logic       tick;       // Minute pulse
  logic [7:0] hr_count;   // Starts in last hour
  logic       start_det;  // Start recognised this cycle

  // Address decode shared by reads and writes
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'b00) && (a <= OFS_REC_TOT);
  endfunction : mapped

  // Byte-lane merge of a write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    for (int i = 0; i < 4; i++)
      merge[8*i +: 8] = s[i] ? d[8*i +: 8] : old[8*i +: 8];
  endfunction : merge

  // Minute time base
  mfsl_minute_tick #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .clk_in     (CLK_SYS_IN),
    .reset_n_in (RESET_N_IN),
    .tick_out   (tick)
  );

  // Rolling hour of starts
  mfsl_hour_window #(
    .DEPTH (HOUR_MIN),
    .W     (8)
  ) u_window (
    .clk_in     (CLK_SYS_IN),
    .reset_n_in (RESET_N_IN),
    .tick_in    (tick),
    .start_in   (start_det),
    .count_out  (hr_count)
  );

  // Write address and data are taken together, one write at a time
  logic wr_take;  // Write accepted this cycle
  logic rd_take;  // Read accepted this cycle
  assign wr_take           = S_AXI_AWVALID_IN && S_AXI_WVALID_IN && !r.bvalid;
  assign rd_take           = S_AXI_ARVALID_IN && !r.rvalid;
  assign S_AXI_AWREADY_OUT = wr_take;
  assign S_AXI_WREADY_OUT  = wr_take;
  assign S_AXI_ARREADY_OUT = rd_take;

  // Current level compare against a tenth of nominal
  logic below_tenth;  // Current under 10% of nominal
  assign below_tenth = (20'(CURRENT_IN) * 20'(NOMINAL_DIV)) < 20'(r.nominal);
  // Start only from the armed, stopped state
  assign start_det = r.enable && r.armed && !r.running
                     && (CURRENT_IN > r.start_th);

  // Next state of the whole block
  always_comb
  begin
    logic [7:0]  after_cnt;  // Hour count including this start
    logic [31:0] wv;         // Merged write value
    logic [3:0]  ev;         // Events this cycle
    logic [3:0]  w1c;        // Status bits cleared by write
    logic        was_inh;    // Inhibit before this cycle
    after_cnt = hr_count + 8'h01;
    wv        = '0;
    ev        = '0;
    w1c       = '0;
    was_inh   = r.inhibit;
    next_r    = r;

    // Motor state tracking
    if (!r.enable)
    begin
      next_r.armed   = 1'b0;
      next_r.running = 1'b0;
    end
    else if (start_det)
    begin
      next_r.running = 1'b1;
      next_r.armed   = 1'b0;
    end
    else if (below_tenth)
    begin
      next_r.running = 1'b0;
      next_r.armed   = 1'b1;
    end

    // Minute timers step on the tick; uptime and since count up, the left timers count down
    if (tick)
    begin
      next_r.uptime_min = r.uptime_min + 32'd1;
      if (r.any_start && r.since_min != 16'hffff)
        next_r.since_min = r.since_min + 16'd1;
      if (r.ivl_left != 8'h00)
        next_r.ivl_left = r.ivl_left - 8'h01;
      if (r.hour_left != 7'h00)
        next_r.hour_left = r.hour_left - 7'h01;
      if (r.alarm_left != 7'h00)
        next_r.alarm_left = r.alarm_left - 7'h01;
      else
        next_r.alarm = 1'b0;
      if (r.alarm_left == 7'h01)
        next_r.alarm = 1'b0;
      if (r.force_on)
      begin
        next_r.force_left = r.force_left - 3'h1;
        if (r.force_left <= 3'h1)
          next_r.force_on = 1'b0;
      end
    end

    // A start reloads interval and checks the hourly limit
    if (start_det)
    begin
      next_r.any_start = 1'b1;
      next_r.since_min = 16'h0000;
      next_r.counter   = r.counter + 32'd1;
      next_r.ivl_left  = r.interval;
      if (after_cnt >= r.max_starts)
      begin
        next_r.hour_left  = 7'(HOUR_MIN);
        next_r.alarm      = 1'b0;
        next_r.alarm_left = 7'h00;
      end
      else if (after_cnt == r.max_starts - 8'h01)
      begin
        next_r.alarm      = 1'b1;
        next_r.alarm_left = 7'(HOUR_MIN);
      end
    end
    next_r.inhibit = (next_r.ivl_left != 8'h00) || (next_r.hour_left != 7'h00);

    // A new inhibit is a trip and is recorded
    if (next_r.inhibit && !was_inh)
    begin
      next_r.trip_record.stamp_min = r.uptime_min;
      next_r.trip_record.starts_hr = start_det ? after_cnt : hr_count;
      next_r.trip_record.since_min = next_r.since_min;
      next_r.trip_record.total     = next_r.counter;
      next_r.trip_record.ftype     = (next_r.hour_left != 7'h00) ? FT_HOURLY : FT_INTERVAL;
    end

    // Edge events
    ev[EV_ALARM_ON]  = next_r.alarm && !r.alarm;
    ev[EV_ALARM_OFF] = !next_r.alarm && r.alarm;
    ev[EV_INHIBIT]   = next_r.inhibit && !was_inh;
    ev[EV_PERMIT]    = !next_r.inhibit && was_inh;

    // Panel press restarts the force timeout
    if (PANEL_BUTTON_IN && r.force_on)
      next_r.force_left = 3'(FORCE_TIMEOUT_MIN);

    // Register writes
    if (wr_take)
    begin
      next_r.bvalid = 1'b1;
      next_r.bresp  = mapped(S_AXI_AWADDR_IN) ? RESP_OKAY : RESP_DECERR;
      unique case (S_AXI_AWADDR_IN)
        OFS_CTRL:
        begin
          wv            = merge({30'h0, r.force_on, r.enable}, S_AXI_WDATA_IN, S_AXI_WSTRB_IN);
          next_r.enable = wv[CTRL_ENABLE_BIT];
          if (wv[CTRL_FORCE_BIT] && !r.force_on)
            next_r.force_left = 3'(FORCE_TIMEOUT_MIN);
          next_r.force_on = wv[CTRL_FORCE_BIT];
        end
        OFS_NOMINAL:
        begin
          wv             = merge({16'h0, r.nominal}, S_AXI_WDATA_IN, S_AXI_WSTRB_IN);
          next_r.nominal = wv[15:0];
        end
        OFS_START_TH:
        begin
          wv              = merge({16'h0, r.start_th}, S_AXI_WDATA_IN, S_AXI_WSTRB_IN);
          next_r.start_th = wv[15:0];
        end
        OFS_MAXSTART:
          if (S_AXI_WSTRB_IN[0])
            next_r.max_starts = S_AXI_WDATA_IN[7:0];
        OFS_INTERVAL:
          if (S_AXI_WSTRB_IN[0])
            next_r.interval = S_AXI_WDATA_IN[7:0];
        OFS_IRQ_STAT:
          if (S_AXI_WSTRB_IN[0])
            w1c = S_AXI_WDATA_IN[3:0];
        OFS_IRQ_MASK:
          if (S_AXI_WSTRB_IN[0])
            next_r.irq_mask = S_AXI_WDATA_IN[3:0];
        OFS_MATRIX:
        begin
          wv            = merge(32'(r.matrix), S_AXI_WDATA_IN, S_AXI_WSTRB_IN);
          next_r.matrix = wv[2*NCONT-1:0];
        end
        OFS_FORCEVAL:
          if (S_AXI_WSTRB_IN[0])
            next_r.force_val = S_AXI_WDATA_IN[1:0];
        default:
          next_r.bresp = next_r.bresp;  // Read-only or unmapped
      endcase
    end
    else if (r.bvalid && S_AXI_BREADY_IN)
      next_r.bvalid = 1'b0;

    // Event set wins over a same-cycle clear
    next_r.irq_stat = (r.irq_stat & ~w1c) | ev;

    // Register reads
    if (rd_take)
    begin
      next_r.rvalid = 1'b1;
      next_r.rresp  = mapped(S_AXI_ARADDR_IN) ? RESP_OKAY : RESP_DECERR;
      unique case (S_AXI_ARADDR_IN)
        OFS_CTRL:     next_r.rdata = {30'h0, r.force_on, r.enable};
        OFS_NOMINAL:  next_r.rdata = {16'h0, r.nominal};
        OFS_START_TH: next_r.rdata = {16'h0, r.start_th};
        OFS_MAXSTART: next_r.rdata = {24'h0, r.max_starts};
        OFS_INTERVAL: next_r.rdata = {24'h0, r.interval};
        OFS_STATUS:   next_r.rdata = {16'h0, hr_count, 4'h0, r.running, r.force_on,
                                      r.inhibit, r.alarm};
        OFS_COUNTER:  next_r.rdata = r.counter;
        OFS_SINCE:    next_r.rdata = {16'h0, r.since_min};
        OFS_IRQ_STAT: next_r.rdata = {28'h0, r.irq_stat};
        OFS_IRQ_MASK: next_r.rdata = {28'h0, r.irq_mask};
        OFS_MATRIX:   next_r.rdata = 32'(r.matrix);
        OFS_FORCEVAL: next_r.rdata = {30'h0, r.force_val};
        OFS_REC_STMP: next_r.rdata = r.trip_record.stamp_min;
        OFS_REC_INFO: next_r.rdata = {6'h0, r.trip_record.ftype, r.trip_record.starts_hr,
                                      r.trip_record.since_min};
        OFS_REC_TOT:  next_r.rdata = r.trip_record.total;
        default:      next_r.rdata = 32'h0000_0000;
      endcase
    end
    else if (r.rvalid && S_AXI_RREADY_IN)
      next_r.rvalid = 1'b0;

    // Contacts follow the matrix, forced values override for test
    for (int i = 0; i < NCONT; i++)
      next_r.contact[i] =
        (next_r.matrix[2*i]   && (next_r.force_on ? next_r.force_val[0] : next_r.alarm))
        || (next_r.matrix[2*i+1] && (next_r.force_on ? next_r.force_val[1]
                                                      : next_r.inhibit));
  end

  // Register the state; synchronous active-low reset
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (!RESET_N_IN)
    begin
      r            <= '0;
      r.nominal    <= NOMINAL_RST;
      r.start_th   <= START_TH_RST;
      r.max_starts <= MAXSTART_RST;
      r.interval   <= INTERVAL_RST;
    end
    else
      r <= next_r;
  end

  // Output drive; stage outputs obey the force flag too
  assign ALARM_OUT        = r.force_on ? r.force_val[0] : r.alarm;
  assign INHIBIT_OUT      = r.force_on ? r.force_val[1] : r.inhibit;
  assign CONTACT_OUT      = r.contact;
  assign IRQ_OUT          = |(r.irq_stat & r.irq_mask);
  assign S_AXI_BVALID_OUT = r.bvalid;
  assign S_AXI_BRESP_OUT  = r.bresp;
  assign S_AXI_RVALID_OUT = r.rvalid;
  assign S_AXI_RRESP_OUT  = r.rresp;
  assign S_AXI_RDATA_OUT  = r.rdata;
endmodule : mfsl_top
`default_nettype wire

// file: bench/mfsl_top_sva.sv
// Port-level assertions for the motor frequent start limiter
`timescale 1ns/10ps
`default_nettype none
module mfsl_top_sva
  import mfsl_pkg::*;
#(
  parameter int NCONT = 4  // Output contacts
) (
  input wire logic             CLK_SYS_IN,
  input wire logic             RESET_N_IN,
  input wire logic             S_AXI_AWVALID_IN,
  input wire logic             S_AXI_AWREADY_OUT,
  input wire logic             S_AXI_WVALID_IN,
  input wire logic             S_AXI_WREADY_OUT,
  input wire logic [1:0]       S_AXI_BRESP_OUT,
  input wire logic             S_AXI_BVALID_OUT,
  input wire logic             S_AXI_BREADY_IN,
  input wire logic             S_AXI_ARVALID_IN,
  input wire logic             S_AXI_ARREADY_OUT,
  input wire logic [31:0]      S_AXI_RDATA_OUT,
  input wire logic             S_AXI_RVALID_OUT,
  input wire logic             S_AXI_RREADY_IN,
  input wire logic             ALARM_OUT,
  input wire logic             INHIBIT_OUT,
  input wire logic [NCONT-1:0] CONTACT_OUT,
  input wire logic             IRQ_OUT
);
  // One domain, so one clock and one reset for all
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RESET_N_IN);
  // Bus acceptance and answer timing
  chk_write_ready: assert property (S_AXI_AWVALID_IN && S_AXI_WVALID_IN && !S_AXI_BVALID_OUT
    |-> S_AXI_AWREADY_OUT && S_AXI_WREADY_OUT ##1 S_AXI_BVALID_OUT) else $error("write lost");
  chk_read_ready: assert property (S_AXI_ARVALID_IN && !S_AXI_RVALID_OUT
    |-> S_AXI_ARREADY_OUT ##1 S_AXI_RVALID_OUT) else $error("read lost");
  chk_bresp_hold: assert property (S_AXI_BVALID_OUT && !S_AXI_BREADY_IN
    |=> S_AXI_BVALID_OUT && $stable(S_AXI_BRESP_OUT)) else $error("write answer dropped");
  chk_rdata_hold: assert property (S_AXI_RVALID_OUT && !S_AXI_RREADY_IN
    |=> S_AXI_RVALID_OUT && $stable(S_AXI_RDATA_OUT)) else $error("read answer dropped");
  chk_bvalid_done: assert property (S_AXI_BVALID_OUT && S_AXI_BREADY_IN |=> !S_AXI_BVALID_OUT)
    else $error("write answer repeated");
  chk_rvalid_done: assert property (S_AXI_RVALID_OUT && S_AXI_RREADY_IN |=> !S_AXI_RVALID_OUT)
    else $error("read answer repeated");
  // Outputs come out of reset quiet
  chk_reset_quiet: assert property ($rose(RESET_N_IN) |-> !ALARM_OUT && !INHIBIT_OUT
    && !IRQ_OUT && CONTACT_OUT == '0) else $error("outputs active after reset");
  // Contacts only ever carry alarm or inhibit
  chk_contact_src: assert property (!ALARM_OUT && !INHIBIT_OUT |-> CONTACT_OUT == '0)
    else $error("contact closed without source");
  // Start inhibit never a single-cycle glitch
  chk_inhibit_min: assert property ($rose(INHIBIT_OUT) |-> INHIBIT_OUT [*8])
    else $error("inhibit too short");
endmodule : mfsl_top_sva
bind mfsl_top mfsl_top_sva #(.NCONT(NCONT)) u_sva (.CLK_SYS_IN(CLK_SYS_IN),
  .RESET_N_IN(RESET_N_IN), .S_AXI_AWVALID_IN(S_AXI_AWVALID_IN),
  .S_AXI_AWREADY_OUT(S_AXI_AWREADY_OUT), .S_AXI_WVALID_IN(S_AXI_WVALID_IN),
  .S_AXI_WREADY_OUT(S_AXI_WREADY_OUT), .S_AXI_BRESP_OUT(S_AXI_BRESP_OUT),
  .S_AXI_BVALID_OUT(S_AXI_BVALID_OUT), .S_AXI_BREADY_IN(S_AXI_BREADY_IN),
  .S_AXI_ARVALID_IN(S_AXI_ARVALID_IN), .S_AXI_ARREADY_OUT(S_AXI_ARREADY_OUT),
  .S_AXI_RDATA_OUT(S_AXI_RDATA_OUT), .S_AXI_RVALID_OUT(S_AXI_RVALID_OUT),
  .S_AXI_RREADY_IN(S_AXI_RREADY_IN), .ALARM_OUT(ALARM_OUT), .INHIBIT_OUT(INHIBIT_OUT),
  .CONTACT_OUT(CONTACT_OUT), .IRQ_OUT(IRQ_OUT));
`default_nettype wire

// file: bench/mfsl_motor_model.sv
// Behavioural current front end feeding the limiter
`timescale 1ns/10ps
`default_nettype none
module mfsl_motor_model
  import mfsl_pkg::*;
(
  input  wire logic        clk_in,          // System clock
  input  wire logic [1:0]  mode_in,         // 0 stopped, 1 light load, 2 start surge
  output var  logic [15:0] current_out      // Measured magnitude
);
  // Magnitude steps one cycle after the mode, like a real sampler
  always_ff @(posedge clk_in)
  begin
    case (mode_in)
      2'd0:    current_out <= NOMINAL_RST / 16'd20;    // Well under a tenth of nominal
      2'd1:    current_out <= NOMINAL_RST;             // Above stop level, below threshold
      default: current_out <= START_TH_RST + 16'h0040; // Surge above start threshold
    endcase
  end
endmodule : mfsl_motor_model
`default_nettype wire

// file: bench/tb.sv
// Self-checking bench of the motor frequent start limiter
`timescale 1ns/10ps
`default_nettype none
module tb;
  import mfsl_pkg::*;
  localparam longint TK = 20;           // Short minute keeps the run small
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        btn = 1'b0;
  logic [1:0]  mode = 2'd0;
  logic [7:0]  awaddr = '0;
  logic [7:0]  araddr = '0;
  logic [31:0] wdata = '0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, alarm, inhibit, irq;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata, rd_d;
  logic [3:0]  contact;
  logic [15:0] cur;
  int          error_cnt = 0;
  int          total_checks = 0;
  // Free-running system clock
  always #4 clk = ~clk;
  mfsl_motor_model u_motor (.clk_in(clk), .mode_in(mode), .current_out(cur));
  mfsl_top #(.NCONT(4), .TICK_CYCLES(TK)) DUT (.CLK_SYS_IN(clk), .RESET_N_IN(rst_n),
    .CURRENT_IN(cur), .PANEL_BUTTON_IN(btn), .S_AXI_AWADDR_IN(awaddr),
    .S_AXI_AWVALID_IN(awvalid), .S_AXI_AWREADY_OUT(awready), .S_AXI_WDATA_IN(wdata),
    .S_AXI_WSTRB_IN(4'hf), .S_AXI_WVALID_IN(wvalid), .S_AXI_WREADY_OUT(wready),
    .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid), .S_AXI_BREADY_IN(bready),
    .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid), .S_AXI_ARREADY_OUT(arready),
    .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rvalid),
    .S_AXI_RREADY_IN(rready), .ALARM_OUT(alarm), .INHIBIT_OUT(inhibit),
    .CONTACT_OUT(contact), .IRQ_OUT(irq));
  // Verdict and end of run
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report
  // Four-state compare with report
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check
  // A used-up wait ends the run
  task automatic limit(input int n, input int lim);
    if (n >= lim)
    begin
      check(32'h1, 32'h0, "wait bound");
      final_report();
    end
  endtask : limit
  // Bus write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (n = 0; n < 50 && !(awready && wready); n++) @(posedge clk);
    limit(n, 50);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    @(posedge clk);  // Answer waits one cycle unaccepted
    bready <= 1'b1;
    @(posedge clk);
    for (n = 0; n < 50 && !bvalid; n++) @(posedge clk);
    limit(n, 50);
    check(32'(bresp), 32'(RESP_OKAY), "write response");
    bready <= 1'b0;
  endtask : wr
  // Bus read, data and response taken at the answer edge
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    for (n = 0; n < 50 && !arready; n++) @(posedge clk);
    limit(n, 50);
    arvalid <= 1'b0;
    @(posedge clk);  // Read data must stand while not accepted
    rready <= 1'b1;
    @(posedge clk);
    for (n = 0; n < 50 && !rvalid; n++) @(posedge clk);
    limit(n, 50);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd
  // Read and compare the masked field
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [1:0] r;
    rd(a, rd_d, r);
    check(rd_d & m, e, "register field");
  endtask : rchk
  // Set motor mode and let the front end settle
  task automatic motor(input logic [1:0] m);
    @(posedge clk);
    mode <= m;
    repeat (5) @(posedge clk);
  endtask : motor
  // Wait for inhibit to reach a level
  task automatic wait_inh(input logic lvl, input int lim);
    int n;
    for (n = 0; n < lim && inhibit !== lvl; n++) @(posedge clk);
    limit(n, lim);
  endtask : wait_inh
  // Main sequence
  initial
  begin
    logic [1:0] r;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rchk(OFS_NOMINAL, 32'hffff, {16'h0, NOMINAL_RST});
    rchk(OFS_MAXSTART, 32'hff, {24'h0, MAXSTART_RST});
    rd(8'h3c, rd_d, r);
    check(32'(r), 32'(RESP_DECERR), "unmapped read");
    $display("test reset values done");
    wr(OFS_INTERVAL, 32'h2);
    wr(OFS_MATRIX, 32'h9);               // Contact 0 alarm, contact 1 inhibit
    wr(OFS_IRQ_MASK, 32'hf);
    wr(OFS_CTRL, 32'h1);
    motor(2'd0);
    motor(2'd2);
    check(32'(inhibit), 32'h1, "inhibit at start");
    check(32'(contact), 32'h2, "contacts at start");
    rchk(OFS_COUNTER, 32'hffffffff, 32'h1);
    rchk(OFS_STATUS, 32'hff00, 32'h0100);
    rchk(OFS_IRQ_STAT, 32'hf, 32'h4);
    check(32'(irq), 32'h1, "irq on inhibit");
    wr(OFS_IRQ_STAT, 32'hf);
    check(32'(irq), 32'h0, "irq after clear");
    wait_inh(1'b0, 60);
    rchk(OFS_IRQ_STAT, 32'hf, 32'h8);
    rchk(OFS_SINCE, 32'hffff, 32'h2);
    motor(2'd1);
    motor(2'd2);
    rchk(OFS_COUNTER, 32'hffffffff, 32'h1);
    $display("test first start done");
    motor(2'd0);
    motor(2'd2);
    check(32'(alarm), 32'h1, "alarm one short");
    check(32'(contact), 32'h3, "contacts with alarm");
    wait_inh(1'b0, 60);
    motor(2'd0);
    motor(2'd2);
    check(32'(alarm), 32'h0, "alarm at limit");
    check(32'(inhibit), 32'h1, "inhibit at limit");
    rchk(OFS_IRQ_STAT, 32'hf, 32'hf);
    rchk(OFS_REC_INFO, 32'h03ff0000, {6'h0, FT_HOURLY, 8'h03, 16'h0});
    rchk(OFS_REC_TOT, 32'hffffffff, 32'h3);
    rchk(OFS_STATUS, 32'hff00, 32'h0300);
    wr(OFS_IRQ_MASK, 32'h0);
    check(32'(irq), 32'h0, "irq masked");
    repeat (1100) @(posedge clk);
    check(32'(inhibit), 32'h1, "hourly inhibit held");
    wait_inh(1'b0, 150);
    repeat (40) @(posedge clk);
    rchk(OFS_STATUS, 32'hff00, 32'h0);
    $display("test hourly limit done");
    wr(OFS_FORCEVAL, 32'h3);
    wr(OFS_CTRL, 32'h3);
    check(32'(alarm & inhibit), 32'h1, "forced outputs");
    repeat (3 * TK) @(posedge clk);
    btn <= 1'b1;
    @(posedge clk);
    btn <= 1'b0;
    repeat (3 * TK) @(posedge clk);
    rchk(OFS_STATUS, 32'h4, 32'h4);
    repeat (3 * TK) @(posedge clk);
    rchk(OFS_STATUS, 32'h4, 32'h0);
    check(32'(alarm), 32'h0, "force released");
    $display("test force done");
    final_report();
  end
endmodule : tb
`default_nettype wire
